/* ext_alu.sv */
// Extended memory-operand ALU with its data memory, reached over APB
// Summary of operation
// (RL1) Extended instructions address any memory section directly, ignoring the selected section.
// (RL2) Add with carry to work: work gets work plus byte plus carry, five arithmetic flags update.
// (RL3) Add with carry to memory: the byte gets work plus byte plus carry, five flags update.
// (RL4) Add to work: work gets work plus byte with no carry in, five flags update.
// (RL5) Add to memory: the byte gets work plus byte with no carry in, five flags update.
// (RL6) And to work: work gets work AND byte, only the zero flag updates.
// (RL7) And to memory: the byte gets work AND byte, only the zero flag updates.
// (RL8) Clear byte: the byte becomes zero and no flag changes.
// (RL9) Clear bit: only the chosen bit of the byte becomes zero and no flag changes.
// (RL10) The zero flag is set when the eight-bit result is zero and cleared otherwise.
`timescale 1ns/1ps
module ext_alu (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ext_alu_pkg::*;

  logic [7:0] mem [MEM_DEPTH];

  state_t state, next_state;
  cmd_t cmd, next_cmd;
  logic [7:0] work, next_work;
  flags_t flags, next_flags;
  logic [SECT_W-1:0] section, next_section;
  logic [OFFS_W-1:0] mem_ptr, next_mem_ptr;
  logic rd_valid, next_rd_valid;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] operand;
  alu_t sum_res;
  logic [7:0] and_res;
  logic apb_done;
  logic mapped;

  // Eight-bit add; the carry into bit 7 XOR the carry out of bit 7 gives the signed overflow
  function automatic alu_t add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    logic c7;
    alu_t r;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    c7 = a[7] ^ b[7] ^ full[7];
    r.res = full[7:0];
    r.flags.unsigned_wrap_bit = full[8];
    r.flags.low_nibble_wrap_bit = low[4];
    r.flags.result_is_nil = (full[7:0] == 8'h00);
    r.flags.signed_wrap_bit = c7 ^ full[8];
    r.flags.signed_result_flag = full[7] ^ c7 ^ full[8];
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFF_COMMAND || a == OFF_WORK || a == OFF_FLAGS || a == OFF_SECTION ||
           a == OFF_MEM_PTR || a == OFF_MEM_DATA;
  endfunction

  // Operand comes from the full command address, never from the section register
  assign operand = mem[cmd.addr]; // RL1
  assign sum_res = add8(work, operand,
    (cmd.op == OP_ADD_CARRY_WORK || cmd.op == OP_ADD_CARRY_MEM) ?
    flags.unsigned_wrap_bit : 1'b0);
  assign and_res = work & operand;

  // A two-cycle access phase lets read data come from a flop, fresh after any execution
  assign pready = psel & penable & rd_valid;
  assign apb_done = pready;
  assign mapped = is_mapped(paddr);

  always_comb begin
    next_rd_valid = rd_valid;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (apb_done) begin
      next_rd_valid = 1'b0;
    end else if (psel && penable && state == ST_IDLE) begin
      next_rd_valid = 1'b1;
      next_pslverr = ~mapped;
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          OFF_COMMAND: next_prdata = {16'h0000, cmd.addr, 1'b0, cmd.bit_idx, cmd.op};
          OFF_WORK: next_prdata = {24'h00_0000, work};
          OFF_FLAGS: next_prdata = {27'h000_0000, flags};
          OFF_SECTION: next_prdata = {30'h0000_0000, section};
          OFF_MEM_PTR: next_prdata = {26'h000_0000, mem_ptr};
          OFF_MEM_DATA: next_prdata = {24'h00_0000, mem[{section, mem_ptr}]};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_work = work;
    next_flags = flags;
    next_section = section;
    next_mem_ptr = mem_ptr;
    mem_we = 1'b0;
    mem_waddr = cmd.addr;
    mem_wdata = operand;
    unique case (state)
      ST_IDLE: begin
        if (apb_done && pwrite) begin
          unique case (paddr)
            OFF_COMMAND: begin
              // Fields are picked one by one: the struct is narrower than the register layout
              next_cmd.addr = pwdata[CMD_ADDR_LSB +: ADDR_W];
              next_cmd.bit_idx = pwdata[CMD_BIT_LSB +: 3];
              next_cmd.op = op_t'(pwdata[CMD_OP_LSB +: 4]);
              next_state = ST_EXEC;
            end
            OFF_WORK: next_work = pwdata[7:0];
            OFF_FLAGS: next_flags = flags_t'(pwdata[FLAG_SC:FLAG_C]);
            OFF_SECTION: next_section = pwdata[SECT_W-1:0];
            OFF_MEM_PTR: next_mem_ptr = pwdata[OFFS_W-1:0];
            OFF_MEM_DATA: begin
              // Plain memory port goes through the selected section
              mem_we = 1'b1;
              mem_waddr = {section, mem_ptr};
              mem_wdata = pwdata[7:0];
            end
            default: ;
          endcase
        end
      end
      ST_EXEC: begin
        next_state = ST_IDLE;
        unique case (cmd.op)
          OP_ADD_CARRY_WORK, OP_ADD_WORK: begin
            next_work = sum_res.res; // RL2 RL4
            next_flags = sum_res.flags; // RL2 RL4 RL10
          end
          OP_ADD_CARRY_MEM, OP_ADD_MEM: begin
            mem_we = 1'b1;
            mem_wdata = sum_res.res; // RL3 RL5
            next_flags = sum_res.flags; // RL3 RL5 RL10
          end
          OP_AND_WORK: begin
            next_work = and_res; // RL6
            next_flags.result_is_nil = (and_res == 8'h00); // RL6 RL10
          end
          OP_AND_MEM: begin
            mem_we = 1'b1;
            mem_wdata = and_res; // RL7
            next_flags.result_is_nil = (and_res == 8'h00); // RL7 RL10
          end
          OP_CLEAR_BYTE: begin
            mem_we = 1'b1;
            mem_wdata = CLEARED_BYTE; // RL8
          end
          OP_CLEAR_BIT: begin
            mem_we = 1'b1;
            mem_wdata = operand & ~(8'h01 << cmd.bit_idx); // RL9
          end
          // Unknown opcodes retire with no effect
          default: ;
        endcase
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      cmd <= '0;
      work <= WORK_RST;
      flags <= flags_t'(FLAGS_RST);
      section <= SECTION_RST;
      mem_ptr <= MEM_PTR_RST;
      rd_valid <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      work <= next_work;
      flags <= next_flags;
      section <= next_section;
      mem_ptr <= next_mem_ptr;
      rd_valid <= next_rd_valid;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Memory contents are not reset; software clears what it uses
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic exec_now;
  assign exec_now = (state == ST_EXEC);

  direct_operand_a: assert property ( // RL1
    exec_now && cmd.op == OP_ADD_MEM && cmd.addr[ADDR_W-1:OFFS_W] != section
    |=> mem[$past(cmd.addr)] == $past(work + operand))
    else $error("extended access did not reach the addressed section");

  add_carry_work_a: assert property ( // RL2
    exec_now && cmd.op == OP_ADD_CARRY_WORK
    |=> work == $past(work + operand + {7'h00, flags.unsigned_wrap_bit})
        && flags.unsigned_wrap_bit == $past({1'b0, work} + {1'b0, operand}
           + {8'h00, flags.unsigned_wrap_bit} > 9'h0ff))
    else $error("add with carry to work gave a wrong sum or carry");

  add_carry_mem_a: assert property ( // RL3
    exec_now && cmd.op == OP_ADD_CARRY_MEM
    |=> mem[$past(cmd.addr)] == $past(work + operand + {7'h00, flags.unsigned_wrap_bit})
        && work == $past(work))
    else $error("add with carry to memory gave a wrong byte");

  add_work_a: assert property ( // RL4
    exec_now && cmd.op == OP_ADD_WORK
    |=> work == $past(work + operand)
        && flags.low_nibble_wrap_bit == $past(({1'b0, work[3:0]} + {1'b0, operand[3:0]}) > 5'h0f))
    else $error("add to work gave a wrong sum or nibble carry");

  add_mem_a: assert property ( // RL5
    exec_now && cmd.op == OP_ADD_MEM
    |=> mem[$past(cmd.addr)] == $past(work + operand)
        && flags.signed_wrap_bit == $past(work[7] == operand[7]
           && (work + operand) >> 7 != {7'h00, work[7]}))
    else $error("add to memory gave a wrong byte or overflow");

  and_work_a: assert property ( // RL6
    exec_now && cmd.op == OP_AND_WORK
    |=> work == $past(work & operand)
        && flags.unsigned_wrap_bit == $past(flags.unsigned_wrap_bit)
        && flags.signed_wrap_bit == $past(flags.signed_wrap_bit))
    else $error("and to work wrong or touched arithmetic flags");

  and_mem_a: assert property ( // RL7
    exec_now && cmd.op == OP_AND_MEM
    |=> mem[$past(cmd.addr)] == $past(work & operand) && work == $past(work)
        && flags.low_nibble_wrap_bit == $past(flags.low_nibble_wrap_bit))
    else $error("and to memory wrong or touched arithmetic flags");

  clear_byte_a: assert property ( // RL8
    exec_now && cmd.op == OP_CLEAR_BYTE
    |=> mem[$past(cmd.addr)] == 8'h00 && flags == $past(flags))
    else $error("clear byte left bits set or changed a flag");

  clear_bit_a: assert property ( // RL9
    exec_now && cmd.op == OP_CLEAR_BIT
    |=> mem[$past(cmd.addr)] == $past(operand & ~(8'h01 << cmd.bit_idx))
        && flags == $past(flags))
    else $error("clear bit touched other bits or a flag");

  nil_flag_a: assert property ( // RL10
    exec_now && cmd.op inside {OP_ADD_WORK, OP_ADD_CARRY_WORK, OP_AND_WORK}
    ##1 1'b1 |-> flags.result_is_nil == (work == 8'h00))
    else $error("zero flag does not match the result");

  apb_wait_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("access phase stretched beyond two cycles");

  carry_mem_flag_a: assert property ( // RL3
    exec_now && cmd.op == OP_ADD_CARRY_MEM
    |=> flags.unsigned_wrap_bit == $past({1'b0, work} + {1'b0, operand}
        + {8'h00, flags.unsigned_wrap_bit} > 9'h0ff))
    else $error("add with carry to memory gave a wrong carry");

  add_work_sign_a: assert property ( // RL4
    exec_now && cmd.op == OP_ADD_WORK
    |=> flags.signed_result_flag == $past(({work[7], work} + {operand[7], operand}) > 9'h0ff))
    else $error("add to work gave a wrong signed result flag");

  add_mem_keep_a: assert property ( // RL5
    exec_now && cmd.op == OP_ADD_MEM
    |=> work == $past(work) && flags.result_is_nil == ($past(work + operand) == 8'h00))
    else $error("add to memory changed work or set a wrong zero flag");

  and_work_keep_a: assert property ( // RL6
    exec_now && cmd.op == OP_AND_WORK
    |=> flags.low_nibble_wrap_bit == $past(flags.low_nibble_wrap_bit)
        && flags.signed_result_flag == $past(flags.signed_result_flag))
    else $error("and to work touched a nibble or sign flag");

  and_mem_keep_a: assert property ( // RL7
    exec_now && cmd.op == OP_AND_MEM
    |=> flags.unsigned_wrap_bit == $past(flags.unsigned_wrap_bit)
        && flags.signed_result_flag == $past(flags.signed_result_flag)
        && flags.result_is_nil == ($past(work & operand) == 8'h00))
    else $error("and to memory set a wrong zero flag or touched others");

  clear_keep_work_a: assert property ( // RL8 RL9
    exec_now && cmd.op inside {OP_CLEAR_BYTE, OP_CLEAR_BIT}
    |=> work == $past(work))
    else $error("a clear operation changed work");

  exec_once_a: assert property (
    exec_now |=> !exec_now)
    else $error("a command ran for more than one cycle");

  unmapped_err_a: assert property (
    pready && paddr > OFF_MEM_DATA |-> pslverr)
    else $error("access above the register map gave no error");

endmodule // ext_alu

/* ext_alu_host.sv */
// APB master model standing in for the core's instruction decoder
`timescale 1ns/1ps
module ext_alu_host (
  // Clock
  input wire logic ref_clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // The xfer drivers move by non-blocking assignment, so pready read just after an edge
  // is the value that edge sampled
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // ext_alu_host

/* ext_alu_pkg.sv */
// Package: register map, field layout, opcodes and carriers for the extended memory ALU
package ext_alu_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_WORK = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_SECTION = 8'h0c;
  localparam logic [7:0] OFF_MEM_PTR = 8'h10;
  localparam logic [7:0] OFF_MEM_DATA = 8'h14;

  // Data memory geometry: section number above the in-section offset
  localparam int ADDR_W = 8;
  localparam int SECT_W = 2;
  localparam int OFFS_W = ADDR_W - SECT_W;
  localparam int MEM_DEPTH = 256;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 4;
  localparam int CMD_ADDR_LSB = 8;

  // Flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;

  // Reset values, and the value written by clear byte
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [SECT_W-1:0] SECTION_RST = 2'h0;
  localparam logic [OFFS_W-1:0] MEM_PTR_RST = 6'h00;
  localparam logic [7:0] CLEARED_BYTE = 8'h00;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD_CARRY_WORK = 4'h1,
    OP_ADD_CARRY_MEM = 4'h2,
    OP_ADD_WORK = 4'h3,
    OP_ADD_MEM = 4'h4,
    OP_AND_WORK = 4'h5,
    OP_AND_MEM = 4'h6,
    OP_CLEAR_BYTE = 4'h7,
    OP_CLEAR_BIT = 4'h8
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [2:0] bit_idx;
    op_t op;
  } cmd_t;

  typedef struct packed {
    logic signed_result_flag;
    logic signed_wrap_bit;
    logic result_is_nil;
    logic low_nibble_wrap_bit;
    logic unsigned_wrap_bit;
  } flags_t;

  typedef struct packed {
    logic [7:0] res;
    flags_t flags;
  } alu_t;

endpackage

/* extended_memory_alu_ops_tb_top.sv */
// Self-checking bench: every extended operation run through APB and checked
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module extended_memory_alu_ops_tb_top;
  import ext_alu_pkg::*;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int err_total = 0;
  int checked = 0;
  // {op, work, byte, flags, bit}; the last one is an unused opcode
  logic [31:0] cases [10] = '{32'h17f00010, 32'h2ff00010, 32'h30f01010, 32'h48080000,
    32'h5f00f1b0, 32'h63cf6040, 32'h755aa1f0, 32'h800ff0a7, 32'h81201150, 32'h9aa55130};

  ext_alu dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ext_alu_host host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Returns {flags, work, byte} after the operation
  function automatic logic [20:0] model(input logic [3:0] op, input logic [7:0] w,
                                        input logic [7:0] m, input logic [4:0] f,
                                        input logic [2:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r, nw, nm;
    logic [4:0] nf;
    logic cin, ov;
    cin = (op == 4'h1 || op == 4'h2) ? f[0] : 1'b0;
    s = {1'b0, w} + {1'b0, m} + {8'h00, cin};
    h = {1'b0, w[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    ov = (w[7] == m[7]) && (s[7] != w[7]);
    r = (op > 4'h4) ? (w & m) : s[7:0];
    nw = w;
    nm = m;
    nf = f;
    if (op != 4'h0 && op < 4'h7) begin
      nf[2] = (r == 8'h00);
      if (op[0]) nw = r;
      else nm = r;
    end
    if (op != 4'h0 && op < 4'h5) nf = {ov ^ r[7], ov, r == 8'h00, h[4], s[8]};
    if (op == 4'h7) nm = 8'h00;
    if (op == 4'h8) nm[b] = 1'b0;
    return {nf, nw, nm};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    host.xfer(1'b1, a, d, r, x);
  endtask

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic summarize();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A full run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end

  initial begin : main
    logic [20:0] x;
    logic [1:0] sec;
    logic [5:0] off;
    logic [31:0] c;
    srst = 1'b1;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    rd(OFF_WORK);
    `CHK("work reset", {24'h0, WORK_RST}, q)
    `CHK("mapped err", 1'b0, e)
    rd(OFF_FLAGS);
    `CHK("flags reset", {27'h0, FLAGS_RST}, q)
    rd(8'h18);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    for (int i = 0; i < 10; i++) begin
      c = cases[i];
      sec = 2'(i);
      off = 6'(5 + i);
      x = model(c[31:28], c[27:20], c[19:12], c[8:4], c[2:0]);
      wr(OFF_SECTION, {30'h0, sec});
      wr(OFF_MEM_PTR, {26'h0, off});
      wr(OFF_MEM_DATA, {24'h0, c[19:12]});
      wr(OFF_WORK, {24'h0, c[27:20]});
      wr(OFF_FLAGS, {27'h0, c[8:4]});
      // Select another section so the command must ignore it
      wr(OFF_SECTION, {30'h0, ~sec});
      wr(OFF_COMMAND, {16'h0, sec, off, 1'b0, c[2:0], c[31:28]});
      rd(OFF_WORK);
      `CHK("work", {24'h0, x[15:8]}, q)
      rd(OFF_FLAGS);
      `CHK("flags", {27'h0, x[20:16]}, q)
      wr(OFF_SECTION, {30'h0, sec});
      rd(OFF_MEM_DATA);
      `CHK("byte", {24'h0, x[7:0]}, q)
    end
    summarize();
  end
endmodule // extended_memory_alu_ops_tb_top
